/* rtl/txe_exec.sv */
// Execution unit for table write, test-skip-if-zero and the XOR instructions.
//
// The placing of the registers and the APB register port are this design's own decisions.
module txe_exec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] file_rdata,
  input wire logic [11:0] third_ptr,
  output logic [11:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we
);
  // ****************************************************************
  // State
  // ****************************************************************
  txe_pkg::txe_state_t st_q, st_d;
  txe_pkg::txe_dec_t dec;
  logic [1:0] q_q, q_d;
  logic [15:0] instr_q, instr_d;
  logic two_q, two_d, pend_q, pend_d;
  logic [7:0] acc_q, acc_d, opnd_q, opnd_d, res_q, res_d;
  logic [7:0] tlat_q, tlat_d, cap_q, cap_d;
  logic [3:0] bank_q, bank_d;
  logic [20:0] tp_q, tp_d;
  logic n_q, n_d, z_q, z_d, ext_q, ext_d;
  logic skip_q, skip_d, ret_q, ret_d;
  logic [11:0] fa_q, fa_d;
  logic [7:0] fw_q, fw_d;
  logic fwe_q, fwe_d;
  logic [31:0] prd_q, prd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  logic [7:0] hold_q [txe_pkg::HOLD_N];
  logic [7:0] hold_d [txe_pkg::HOLD_N];
  logic acc_ph, done, busy;
  logic [11:0] eff;

  assign prdata = prd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign file_addr = fa_q;
  assign file_wdata = fw_q;
  assign file_we = fwe_q;

  // ****************************************************************
  // Decode and addressing
  // ****************************************************************
  always_comb begin
    dec = '0;
    dec.xor_literal_into_acc = instr_q[15:8] == txe_pkg::OP_XOR_LITERAL_INTO_ACC;
    dec.xor_acc_with_file = instr_q[15:10] == txe_pkg::OP_XOR_ACC_WITH_FILE;
    dec.test_skip_if_zero = instr_q[15:9] == txe_pkg::OP_TEST_SKIP_IF_ZERO;
    dec.table_write_instr = instr_q[15:2] == txe_pkg::OP_TABLE_WRITE_INSTR;
    // Pointer arithmetic only decodes with the extended set enabled.
    dec.ptr_arith = ext_q && instr_q[15:9] == txe_pkg::OP_PTRARITH;
    dec.ptr_ret = dec.ptr_arith && instr_q[7:6] == txe_pkg::PTR_THIRD;
    dec.dest_file = instr_q[9];
    dec.use_bank = instr_q[8];
    dec.f = instr_q[7:0];
    dec.mode = instr_q[1:0];
    if (dec.use_bank) begin
      eff = {bank_q, dec.f};
    end else if (ext_q && dec.f <= txe_pkg::ILO_MAX) begin
      eff = third_ptr + {4'h0, dec.f};
    end else if (dec.f[7]) begin
      eff = {txe_pkg::ACC_HI_BANK, dec.f};
    end else begin
      eff = {txe_pkg::ACC_LO_BANK, dec.f};
    end
  end

  // ****************************************************************
  // Bus and execution next state
  // ****************************************************************
  always_comb begin
    acc_ph = psel && penable;
    done = acc_ph && rdy_q;
    busy = st_q != txe_pkg::ST_IDLE || pend_q;
    q_d = q_q + 2'h1;
    st_d = st_q;
    instr_d = instr_q;
    two_d = two_q;
    pend_d = pend_q;
    acc_d = acc_q;
    opnd_d = opnd_q;
    res_d = res_q;
    tlat_d = tlat_q;
    cap_d = cap_q;
    bank_d = bank_q;
    tp_d = tp_q;
    n_d = n_q;
    z_d = z_q;
    ext_d = ext_q;
    skip_d = skip_q;
    ret_d = ret_q;
    fa_d = fa_q;
    fw_d = fw_q;
    fwe_d = 1'b0;
    hold_d = hold_q;
    rdy_d = acc_ph && !rdy_q;
    prd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (acc_ph && !rdy_q) begin
      err_d = paddr[1:0] != 2'h0;
      if (paddr[7:5] == txe_pkg::HOLD_PAGE) begin
        prd_d = {24'h00_0000, hold_q[paddr[4:2]]};
        err_d = err_d || pwrite;
      end else begin
        unique case (paddr)
          txe_pkg::OFF_INSTR: prd_d = {15'h0000, two_q, instr_q};
          txe_pkg::OFF_ACC: prd_d = {24'h00_0000, acc_q};
          txe_pkg::OFF_BANK: prd_d = {28'h000_0000, bank_q};
          txe_pkg::OFF_TPTR: prd_d = {11'h000, tp_q};
          txe_pkg::OFF_TLAT: prd_d = {24'h00_0000, tlat_q};
          txe_pkg::OFF_STAT: prd_d = {27'h000_0000, ret_q, skip_q, busy, n_q, z_q};
          txe_pkg::OFF_CFG: prd_d = {31'h0000_0000, ext_q};
          default: err_d = 1'b1;
        endcase
      end
    end
    // Software writes land first so that the sequencer below overrides them.
    if (done && pwrite && !pslverr) begin
      unique case (paddr)
        txe_pkg::OFF_INSTR: begin
          if (!busy) begin
            instr_d = pwdata[15:0];
            two_d = pwdata[16];
            pend_d = 1'b1;
            skip_d = 1'b0;
            ret_d = 1'b0;
          end
        end
        txe_pkg::OFF_ACC: acc_d = pwdata[7:0];
        txe_pkg::OFF_BANK: bank_d = pwdata[3:0];
        txe_pkg::OFF_TPTR: tp_d = pwdata[20:0];
        txe_pkg::OFF_TLAT: tlat_d = pwdata[7:0];
        txe_pkg::OFF_CFG: ext_d = pwdata[0];
        default: ;
      endcase
    end
    unique case (st_q)
      txe_pkg::ST_IDLE: begin
        // Start on a cycle boundary so Q1 lines up with the decode phase.
        if (pend_q && q_q == txe_pkg::Q4) begin
          pend_d = 1'b0;
          st_d = txe_pkg::ST_EXEC;
        end
      end
      txe_pkg::ST_EXEC: begin
        unique case (q_q)
          txe_pkg::Q1: fa_d = eff;
          txe_pkg::Q2: opnd_d = dec.xor_literal_into_acc ? dec.f : file_rdata;
          txe_pkg::Q3: res_d = dec.test_skip_if_zero ? opnd_q : acc_q ^ opnd_q;
          txe_pkg::Q4: begin
            st_d = txe_pkg::ST_IDLE;
            if (dec.xor_literal_into_acc || dec.xor_acc_with_file) begin
              n_d = res_q[7];
              z_d = res_q == 8'h00;
              if (dec.xor_acc_with_file && dec.dest_file) begin
                fw_d = res_q;
                fwe_d = 1'b1;
              end else begin
                acc_d = res_q;
              end
            end else if (dec.test_skip_if_zero && res_q == 8'h00) begin
              skip_d = 1'b1;
              st_d = txe_pkg::ST_SKIP1;
            end else if (dec.table_write_instr) begin
              st_d = txe_pkg::ST_TW2;
              if (dec.mode == txe_pkg::TW_PRE_INC) begin
                tp_d = tp_q + txe_pkg::TP_ONE;
              end
            end else if (dec.ptr_ret) begin
              ret_d = 1'b1;
            end
          end
          default: ;
        endcase
      end
      txe_pkg::ST_TW2: begin
        if (q_q == txe_pkg::Q2) begin
          cap_d = tlat_q;
        end
        if (q_q == txe_pkg::Q4) begin
          hold_d[tp_q[2:0]] = cap_q;
          if (dec.mode == txe_pkg::TW_POST_INC) begin
            tp_d = tp_q + txe_pkg::TP_ONE;
          end else if (dec.mode == txe_pkg::TW_POST_DEC) begin
            tp_d = tp_q - txe_pkg::TP_ONE;
          end
          st_d = txe_pkg::ST_IDLE;
        end
      end
      txe_pkg::ST_SKIP1: begin
        if (q_q == txe_pkg::Q4) begin
          st_d = two_q ? txe_pkg::ST_SKIP2 : txe_pkg::ST_IDLE;
        end
      end
      txe_pkg::ST_SKIP2: begin
        if (q_q == txe_pkg::Q4) begin
          st_d = txe_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= txe_pkg::ST_IDLE;
      q_q <= txe_pkg::Q1;
      instr_q <= 16'h0000;
      two_q <= 1'b0;
      pend_q <= 1'b0;
      acc_q <= txe_pkg::ACC_RST;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      tlat_q <= txe_pkg::TLAT_RST;
      cap_q <= 8'h00;
      bank_q <= txe_pkg::BANK_RST;
      tp_q <= txe_pkg::TP_RST;
      n_q <= 1'b0;
      z_q <= 1'b0;
      ext_q <= txe_pkg::EXT_RST;
      skip_q <= 1'b0;
      ret_q <= 1'b0;
      fa_q <= 12'h000;
      fw_q <= 8'h00;
      fwe_q <= 1'b0;
      prd_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      q_q <= q_d;
      instr_q <= instr_d;
      two_q <= two_d;
      pend_q <= pend_d;
      acc_q <= acc_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      tlat_q <= tlat_d;
      cap_q <= cap_d;
      bank_q <= bank_d;
      tp_q <= tp_d;
      n_q <= n_d;
      z_q <= z_d;
      ext_q <= ext_d;
      skip_q <= skip_d;
      ret_q <= ret_d;
      fa_q <= fa_d;
      fw_q <= fw_d;
      fwe_q <= fwe_d;
      prd_q <= prd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  for (genvar i = 0; i < txe_pkg::HOLD_N; i++) begin : g_hold
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        hold_q[i] <= txe_pkg::HOLD_RST;
      end else begin
        hold_q[i] <= hold_d[i];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic ex4;
  assign ex4 = st_q == txe_pkg::ST_EXEC && q_q == txe_pkg::Q4;

  chk_xor_literal_into_acc_acc: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && dec.xor_literal_into_acc |=> acc_q == ($past(acc_q) ^ $past(instr_q[7:0])))
    else $error("xor literal result wrong");
  chk_xor_acc_with_file_dest: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && dec.xor_acc_with_file && dec.dest_file |=> fwe_q && acc_q == $past(acc_q))
    else $error("xor file result not written to file");
  chk_xor_flags: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && (dec.xor_acc_with_file || dec.xor_literal_into_acc) |=> z_q == ($past(res_q) == 8'h00) && n_q == $past(res_q[7]))
    else $error("xor flags wrong");
  chk_skip_nop: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && dec.test_skip_if_zero && res_q == 8'h00 |=> st_q == txe_pkg::ST_SKIP1 [*4])
    else $error("skip cycle missing");
  chk_skip_flags: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && dec.test_skip_if_zero |=> $stable(n_q) && $stable(z_q))
    else $error("test skip changed flags");
  chk_skip_two: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == txe_pkg::ST_SKIP1 && q_q == txe_pkg::Q4 && two_q |=> st_q == txe_pkg::ST_SKIP2 [*4]
    ##1 st_q == txe_pkg::ST_IDLE)
    else $error("two-word skip length wrong");
  chk_table_write_instr_hold: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == txe_pkg::ST_TW2 && q_q == txe_pkg::Q4 |=> hold_q[$past(tp_q[2:0])] == $past(cap_q))
    else $error("holding register not written");
  chk_table_write_instr_len: assert property (@(posedge clk) disable iff (!rst_b)
    ex4 && dec.table_write_instr |=> st_q == txe_pkg::ST_TW2 [*4] ##1 st_q == txe_pkg::ST_IDLE)
    else $error("table write length wrong");
  chk_post_inc: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == txe_pkg::ST_TW2 && q_q == txe_pkg::Q4 && dec.mode == txe_pkg::TW_POST_INC
    |=> tp_q == $past(tp_q) + txe_pkg::TP_ONE)
    else $error("post increment wrong");
  chk_ilo_addr: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == txe_pkg::ST_EXEC && q_q == txe_pkg::Q1 && !dec.use_bank && ext_q
    && dec.f <= txe_pkg::ILO_MAX |=> file_addr == $past(third_ptr) + {4'h0, $past(dec.f)})
    else $error("indexed address wrong");
  chk_bank_addr: assert property (@(posedge clk) disable iff (!rst_b)
    st_q == txe_pkg::ST_EXEC && q_q == txe_pkg::Q1 && dec.use_bank
    |=> file_addr == {$past(bank_q), $past(dec.f)})
    else $error("banked address wrong");
endmodule

/* rtl/txe_pkg.sv */
// Shared constants and types for the table-write, skip and XOR execution block.
package txe_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_BANK = 8'h08;
  localparam logic [7:0] OFF_TPTR = 8'h0C;
  localparam logic [7:0] OFF_TLAT = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [2:0] HOLD_PAGE = 3'h1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] TLAT_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'hFF;
  localparam logic EXT_RST = 1'b0;
  // ****************************************************************
  // Opcodes and addressing
  // ****************************************************************
  localparam logic [7:0] OP_XOR_LITERAL_INTO_ACC = 8'h0A;
  localparam logic [5:0] OP_XOR_ACC_WITH_FILE = 6'h06;
  localparam logic [6:0] OP_TEST_SKIP_IF_ZERO = 7'h33;
  localparam logic [13:0] OP_TABLE_WRITE_INSTR = 14'h0003;
  localparam logic [6:0] OP_PTRARITH = 7'h74;
  localparam logic [1:0] PTR_THIRD = 2'h3;
  localparam logic [7:0] ILO_MAX = 8'h5F;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [1:0] TW_NONE = 2'h0;
  localparam logic [1:0] TW_POST_INC = 2'h1;
  localparam logic [1:0] TW_POST_DEC = 2'h2;
  localparam logic [1:0] TW_PRE_INC = 2'h3;
  localparam int unsigned PTR_W = 21;
  localparam int unsigned HOLD_N = 8;
  localparam logic [20:0] TP_ONE = 21'h000001;
  localparam logic [20:0] TP_RST = 21'h000000;
  // ****************************************************************
  // Q phases, states and decoded instruction
  // ****************************************************************
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_EXEC = 5'h02,
    ST_TW2 = 5'h04,
    ST_SKIP1 = 5'h08,
    ST_SKIP2 = 5'h10
  } txe_state_t;
  typedef struct packed {
    logic xor_literal_into_acc;
    logic xor_acc_with_file;
    logic test_skip_if_zero;
    logic table_write_instr;
    logic ptr_arith;
    logic ptr_ret;
    logic dest_file;
    logic use_bank;
    logic [7:0] f;
    logic [1:0] mode;
  } txe_dec_t;
endpackage

/* verification/tb.sv */
// Self-checking bench for the table-write, skip and XOR execution block.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals and file register model
  // ****************************************************************
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, file_we, e;
  logic [7:0] paddr, file_rdata, file_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] third_ptr, file_addr;
  logic [7:0] fmem [0:4095];
  logic [1:0] md [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  logic [7:0] lt [4] = '{8'h55, 8'h34, 8'h11, 8'h22};
  logic [20:0] tp [4] = '{21'h00A356, 21'h01389A, 21'h1FFFF1, 21'h000005};
  logic [20:0] te [4] = '{21'h00A357, 21'h01389B, 21'h1FFFF1, 21'h000004};
  logic [2:0] hi;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, t1, t2;

  txe_exec dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .file_rdata(file_rdata), .third_ptr(third_ptr), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The unit samples read data one clock after it moves the address, so the file reads
  // combinationally; a registered model would hand back the previous address's byte.
  assign file_rdata = fmem[file_addr];

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (file_we === 1'b1) begin
      fmem[file_addr] <= file_wdata;
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  // The request holds until the rising edge at which pready is sampled high; read data
  // and the error flag are taken at that same edge, and only then is the request released.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end else begin
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask

  // Every bus call and wait spans a multiple of four clocks, so each run starts on the
  // same Q phase and run times can be compared to the clock.
  task automatic run(input logic [16:0] ins, output int t);
    int c0, n;
    c0 = cyc;
    n = 0;
    wr(txe_pkg::OFF_INSTR, {15'h0000, ins});
    repeat (4) @(posedge clk);
    apb(1'b0, txe_pkg::OFF_STAT, 32'h0);
    while (rd[2] !== 1'b0 && n < 30) begin
      apb(1'b0, txe_pkg::OFF_STAT, 32'h0);
      n++;
    end
    if (n >= 30) begin
      n_mismatch++;
      wrap_up();
    end else begin
      t = cyc - c0;
    end
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    third_ptr = 12'h100;
    for (int i = 0; i < 4096; i++) fmem[i] = 8'h00;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rc("acc reset", txe_pkg::OFF_ACC, 32'h0);
    rc("cfg reset", txe_pkg::OFF_CFG, 32'h0);
    rc("hold0 reset", 8'h20, 32'hFF);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(txe_pkg::OFF_ACC, 32'hB5);
    run(17'h00AAF, t0);
    rc("acc xor literal", txe_pkg::OFF_ACC, 32'h1A);
    run(17'h00A1A, t0);
    rc("zero flag", txe_pkg::OFF_STAT, 32'h01);
    run(17'h00A80, t0);
    rc("negative flag", txe_pkg::OFF_STAT, 32'h02);
    wr(txe_pkg::OFF_BANK, 32'h3);
    wr(txe_pkg::OFF_ACC, 32'hB5);
    fmem[12'h322] = 8'hAF;
    run(17'h01B22, t0);
    chk("banked file result", 32'h1A, {24'h0, fmem[12'h322]});
    rc("acc kept", txe_pkg::OFF_ACC, 32'hB5);
    fmem[12'hF90] = 8'h0F;
    run(17'h01890, t0);
    rc("acc from access bank", txe_pkg::OFF_ACC, 32'hBA);
    fmem[12'h010] = 8'h01;
    run(17'h01A10, t0);
    chk("low access bank", 32'hBB, {24'h0, fmem[12'h010]});
    wr(txe_pkg::OFF_CFG, 32'h1);
    fmem[12'h15F] = 8'h04;
    run(17'h01A5F, t0);
    chk("indexed top", 32'hBE, {24'h0, fmem[12'h15F]});
    fmem[12'h060] = 8'h03;
    run(17'h01A60, t0);
    chk("above indexed range", 32'hB9, {24'h0, fmem[12'h060]});
    run(17'h0E8C5, t0);
    rc("add return", txe_pkg::OFF_STAT, 32'h12);
    run(17'h0E9C1, t0);
    rc("sub return", txe_pkg::OFF_STAT, 32'h12);
    run(17'h0E845, t0);
    rc("other pointer", txe_pkg::OFF_STAT, 32'h02);
    wr(txe_pkg::OFF_CFG, 32'h0);
    run(17'h0E8C5, t0);
    rc("ext disabled", txe_pkg::OFF_STAT, 32'h02);
    fmem[12'h344] = 8'h05;
    run(17'h06744, t0);
    rc("no skip", txe_pkg::OFF_STAT, 32'h02);
    fmem[12'h344] = 8'h00;
    run(17'h06744, t1);
    rc("skip", txe_pkg::OFF_STAT, 32'h0A);
    run(17'h16744, t2);
    rc("skip two-word", txe_pkg::OFF_STAT, 32'h0A);
    // Each skipped instruction cycle adds exactly four clocks.
    chk("skip time", 32'h4, t1 - t0);
    chk("skip two-word time", 32'h4, t2 - t1);
    for (int i = 0; i < 4; i++) begin
      hi = (md[i] == txe_pkg::TW_PRE_INC) ? te[i][2:0] : tp[i][2:0];
      wr(txe_pkg::OFF_TLAT, {24'h0, lt[i]});
      wr(txe_pkg::OFF_TPTR, {11'h0, tp[i]});
      run({15'h0003, md[i]}, t0);
      rc("table pointer", txe_pkg::OFF_TPTR, {11'h0, te[i]});
      rc("holding target", 8'h20 + {3'h0, hi, 2'h0}, {24'h0, lt[i]});
    end
    rc("holding untouched", 8'h28, 32'hFF);
    wr(8'h38, 32'h0);
    chk("holding write error", 32'h1, {31'h0, e});
    rc("holding kept", 8'h38, 32'h55);
    wrap_up();
  end
endmodule
